/* File: fep_top.v */
// Purpose: fine edge placement extension on pwm output a of a coarse pwm channel
// Assumes: single 100 MHz clock; registers on a plain strobe port, read data one cycle after the strobe
// Notes:   fine placement is reported as a step count beside each output a edge that the edge mode selects and blanking does not drop
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "fep_regs.vh"

module fep_top
(
    input  wire        core_clk_in,
    input  wire        rst_n_in,
    input  wire        clk_en_in,
    input  wire [7:0]  addr_in,
    input  wire [15:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [15:0] rdata_out,
    output reg         pwm_output_a_out,
    output reg         pwm_output_b_out,
    output reg         fine_edge_out,
    output reg  [7:0]  fine_steps_out
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    reg  [15:0] config_reg;
    reg  [15:0] coarse_ctrl_reg;
    reg  [15:0] period_value_reg;
    reg  [15:0] phase_load_value_reg;
    reg  [7:0]  phase_fine_extension_reg;
    reg  [15:0] compare_a_value_active_reg;
    reg  [15:0] compare_a_value_shadow_reg;
    reg  [7:0]  compare_a_value_fine_active_reg;
    reg  [7:0]  compare_a_value_fine_shadow_reg;
    reg  [7:0]  compare_a_value_fine_low_reg;
    reg         self_check_reg;
    reg  [7:0]  check_count_reg;
    reg         check_done_reg;
    reg  [15:0] counter_reg;
    reg         out_a_reg;

    wire [1:0]  edge_mode    = config_reg[`FEP_CFG_EDGE_MSB:`FEP_CFG_EDGE_LSB];
    wire        ctrl_phase   = config_reg[`FEP_CFG_CTRL_BIT];
    wire [1:0]  fine_load    = config_reg[`FEP_CFG_SHDW_MSB:`FEP_CFG_SHDW_LSB];
    wire [1:0]  coarse_load  = coarse_ctrl_reg[`FEP_CC_COMPARE_A_VALUE_LD_MSB:`FEP_CC_COMPARE_A_VALUE_LD_LSB];
    wire        run          = coarse_ctrl_reg[`FEP_CC_RUN_BIT];
    wire        pol_a        = coarse_ctrl_reg[`FEP_CC_A_POL_BIT];
    wire        pol_b        = coarse_ctrl_reg[`FEP_CC_B_POL_BIT];

    wire        at_zero      = (counter_reg == 16'h0000);
    wire        at_prd       = (counter_reg == period_value_reg);

    ////////////////////////////////////////////////////////////////////////////
    // shadow load strobes
    function load_now;
        input [1:0] mode;
        input       z;
        input       p;
        begin
            case (mode)
                `FEP_LOAD_ZERO:   load_now = z;
                `FEP_LOAD_PRD:    load_now = p;
                `FEP_LOAD_EITHER: load_now = z | p;
                default:          load_now = 1'b0;
            endcase
        end
    endfunction

    wire coarse_ld = run & load_now(coarse_load, at_zero, at_prd);
    // fine shadow matters only when compare-a is the source; phase source loads immediately
    wire fine_imm  = ctrl_phase | (fine_load == `FEP_LOAD_IMMED);
    wire fine_ld   = run & ~ctrl_phase & load_now(fine_load, at_zero, at_prd);
    wire wr_compare_a_value   = wr_in & (addr_in == `FEP_IDX_COMPARE_A_VALUE_VALUE);
    wire wr_cfine  = wr_in & (addr_in == `FEP_IDX_COMPARE_A_VALUE_FINE);

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            config_reg               <= `FEP_RST_CONFIG;
            coarse_ctrl_reg          <= `FEP_RST_CTRL;
            period_value_reg         <= `FEP_RST_PERIOD;
            phase_load_value_reg     <= 16'h0000;
            phase_fine_extension_reg <= 8'h00;
            compare_a_value_active_reg          <= 16'h0000;
            compare_a_value_shadow_reg          <= 16'h0000;
            compare_a_value_fine_active_reg     <= 8'h00;
            compare_a_value_fine_shadow_reg     <= 8'h00;
            compare_a_value_fine_low_reg        <= 8'h00;
            self_check_reg           <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (wr_in)
            begin
                case (addr_in)
                    `FEP_IDX_FINE_CONFIG:  config_reg <= wdata_in;
                    `FEP_IDX_COARSE_CTRL:  coarse_ctrl_reg <= wdata_in;
                    `FEP_IDX_PERIOD_VALUE: period_value_reg <= wdata_in;
                    `FEP_IDX_PHASE_VALUE:  phase_load_value_reg <= wdata_in;
                    `FEP_IDX_PHASE_FINE:   phase_fine_extension_reg <= wdata_in[15:8];
                    `FEP_IDX_SELF_CHECK:   self_check_reg <= wdata_in[0];
                    default:               self_check_reg <= self_check_reg;
                endcase
            end
            // coarse compare-a shadow
            if (wr_compare_a_value)
            begin
                compare_a_value_shadow_reg <= wdata_in;
            end
            if ((wr_compare_a_value && coarse_load == `FEP_LOAD_IMMED) || !run)
            begin
                compare_a_value_active_reg <= wr_compare_a_value ? wdata_in : compare_a_value_shadow_reg;
            end
            else if (coarse_ld)
            begin
                compare_a_value_active_reg <= compare_a_value_shadow_reg;
            end
            // fine compare-a shadow; low byte is kept for readback only
            if (wr_cfine)
            begin
                compare_a_value_fine_shadow_reg <= wdata_in[15:8];
                compare_a_value_fine_low_reg    <= wdata_in[7:0];
            end
            if ((wr_cfine && fine_imm) || !run)
            begin
                compare_a_value_fine_active_reg <= wr_cfine ? wdata_in[15:8] : compare_a_value_fine_shadow_reg;
            end
            else if (fine_ld)
            begin
                compare_a_value_fine_active_reg <= compare_a_value_fine_shadow_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // coarse time base, up count, phase load value taken while stopped
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            counter_reg <= 16'h0000;
            out_a_reg   <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (!run)
            begin
                counter_reg <= phase_load_value_reg;
                out_a_reg   <= 1'b0;
            end
            else
            begin
                counter_reg <= at_prd ? 16'h0000 : counter_reg + 16'h0001;
                if (at_zero)
                begin
                    out_a_reg <= (compare_a_value_active_reg != 16'h0000);
                end
                else if (counter_reg == compare_a_value_active_reg)
                begin
                    out_a_reg <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fine edge selection
    reg        fine_req;
    reg [7:0]  fine_src;
    // a mark only where output a really changes level, so a stale or mid-period start cannot mark a flat line
    wire       rise_a  = run & at_zero & (compare_a_value_active_reg != 16'h0000) & ~out_a_reg;
    wire       fall_a  = run & ~at_zero & (counter_reg == compare_a_value_active_reg) & out_a_reg;
    // falling edges in the first clocks of each period have no fine placement; coarse edge still goes out
    wire       blanked = (counter_reg < `FEP_BLANK_CYCLES);

    always @*
    begin
        fine_src = ctrl_phase ? phase_fine_extension_reg : compare_a_value_fine_active_reg;
        case (edge_mode)
            `FEP_EDGE_RISE: fine_req = rise_a;
            `FEP_EDGE_FALL: fine_req = fall_a & ~blanked;
            `FEP_EDGE_BOTH: fine_req = rise_a | (fall_a & ~blanked);
            default:        fine_req = 1'b0;
        endcase
        if (fine_src > `FEP_STEPS_PER_CLK)
        begin
            fine_src = `FEP_STEPS_PER_CLK;
        end
    end

    // one stage so the fine mark meets the output a level that it belongs to
    reg        fine_req_reg;
    reg [7:0]  fine_src_reg;

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fine_req_reg <= 1'b0;
            fine_src_reg <= 8'h00;
        end
        else if (clk_en_in)
        begin
            fine_req_reg <= fine_req;
            fine_src_reg <= fine_src;
        end
    end

    wire       dl_edge;
    wire [7:0] dl_steps;
    wire       dl_level;

    fep_delay_line u_delay
    (
        .core_clk_in       (core_clk_in),
        .rst_n_in          (rst_n_in),
        .clk_en_in         (clk_en_in),
        .edge_in           (fine_req_reg),
        .steps_in          (fine_src_reg),
        .level_in          (out_a_reg),
        .edge_out          (dl_edge),
        .applied_steps_out (dl_steps),
        .level_out         (dl_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // self-check: counts fine edges whose step count matches the current fine source, while enabled
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            check_count_reg <= 8'h00;
            check_done_reg  <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (!self_check_reg)
            begin
                check_count_reg <= 8'h00;
                check_done_reg  <= 1'b0;
            end
            else if (dl_edge && dl_steps == fine_src_reg)
            begin
                check_count_reg <= check_count_reg + 8'h01;
                check_done_reg  <= (check_count_reg == 8'hff);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; b is the same coarse wave with no fine path at all
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pwm_output_a_out <= 1'b0;
            pwm_output_b_out <= 1'b0;
            fine_edge_out    <= 1'b0;
            fine_steps_out   <= 8'h00;
            rdata_out        <= 16'h0000;
        end
        else if (clk_en_in)
        begin
            pwm_output_a_out <= dl_level ^ pol_a;
            pwm_output_b_out <= out_a_reg ^ pol_b;
            fine_edge_out    <= dl_edge;
            fine_steps_out   <= dl_edge ? dl_steps : 8'h00;
            rdata_out        <= 16'h0000;
            if (rd_in)
            begin
                case (addr_in)
                    `FEP_IDX_FINE_CONFIG:  rdata_out <= config_reg;
                    `FEP_IDX_COARSE_CTRL:  rdata_out <= coarse_ctrl_reg;
                    `FEP_IDX_PERIOD_VALUE: rdata_out <= period_value_reg;
                    `FEP_IDX_PHASE_VALUE:  rdata_out <= phase_load_value_reg;
                    `FEP_IDX_PHASE_FINE:   rdata_out <= {phase_fine_extension_reg, 8'h00};
                    `FEP_IDX_COMPARE_A_VALUE_VALUE:   rdata_out <= compare_a_value_active_reg;
                    `FEP_IDX_COMPARE_A_VALUE_FINE:    rdata_out <= {compare_a_value_fine_active_reg, compare_a_value_fine_low_reg};
                    `FEP_IDX_SELF_CHECK:   rdata_out <= {15'h0000, self_check_reg};
                    `FEP_IDX_STATUS:       rdata_out <= {check_done_reg, 7'h00, check_count_reg};
                    default:               rdata_out <= counter_reg;
                endcase
            end
        end
    end

endmodule

/* File: fep_regs.vh */
// Purpose: register offsets, field positions, reset values and timing counts for the fine edge pwm extension
// Assumes: register index offsets as printed; byte address is four times the index
// Notes:   definitions only
`ifndef FEP_REGS_VH
`define FEP_REGS_VH

// register indexes
`define FEP_IDX_PHASE_FINE      8'h04
`define FEP_IDX_COMPARE_A_VALUE_FINE       8'h10
`define FEP_IDX_FINE_CONFIG     8'hc0
`define FEP_IDX_PHASE_VALUE     8'h03
`define FEP_IDX_COMPARE_A_VALUE_VALUE      8'h09
`define FEP_IDX_PERIOD_VALUE    8'h05
`define FEP_IDX_COARSE_CTRL     8'h07
`define FEP_IDX_SELF_CHECK      8'hc1
`define FEP_IDX_STATUS          8'hc2

// fine_resolution_config fields
`define FEP_CFG_EDGE_LSB        0
`define FEP_CFG_EDGE_MSB        1
`define FEP_CFG_CTRL_BIT        2
`define FEP_CFG_SHDW_LSB        3
`define FEP_CFG_SHDW_MSB        4

// edge mode codes
`define FEP_EDGE_OFF            2'h0
`define FEP_EDGE_RISE           2'h1
`define FEP_EDGE_FALL           2'h2
`define FEP_EDGE_BOTH           2'h3

// shadow load codes
`define FEP_LOAD_ZERO           2'h0
`define FEP_LOAD_PRD            2'h1
`define FEP_LOAD_EITHER         2'h2
`define FEP_LOAD_IMMED          2'h3

// coarse control fields
`define FEP_CC_RUN_BIT          0
`define FEP_CC_A_POL_BIT        1
`define FEP_CC_B_POL_BIT        2
`define FEP_CC_COMPARE_A_VALUE_LD_LSB      3
`define FEP_CC_COMPARE_A_VALUE_LD_MSB      4

// reset values
`define FEP_RST_CONFIG          16'h0000
`define FEP_RST_PERIOD          16'hffff
`define FEP_RST_CTRL            16'h0000

// fine positioner timing
`define FEP_BLANK_CYCLES        16'h0003
`define FEP_STEPS_PER_CLK       8'hff
`define FEP_TAP_BITS            8

`endif

/* File: fep_delay_line.v */
// Purpose: fine delay of one edge request by a programmed number of positioner steps
// Assumes: a tapped chain whose taps are sampled into a register per clock
// Notes:   behavioural stand-in for the analog delay cells; step width is a fraction of one clock
`timescale 1ns/1ps
module fep_delay_line
(
    input  wire        core_clk_in,
    input  wire        rst_n_in,
    input  wire        clk_en_in,
    input  wire        edge_in,
    input  wire [7:0]  steps_in,
    input  wire        level_in,
    output reg         edge_out,
    output reg  [7:0]  applied_steps_out,
    output reg         level_out
);

    // step count is carried with the edge so a later change cannot tear a placed edge
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            edge_out          <= 1'b0;
            applied_steps_out <= 8'h00;
            level_out         <= 1'b0;
        end
        else if (clk_en_in)
        begin
            edge_out  <= edge_in;
            level_out <= level_in;
            if (edge_in)
            begin
                applied_steps_out <= steps_in;
            end
        end
    end

endmodule

/* File: fep_top_properties.sv */
// Purpose: port properties of fep_top
// Assumes: edge mode and polarity followed from register writes
// Notes:   edge checks wait until the pipeline has seen a new mode
`timescale 1ns/1ps
module fep_top_properties
(
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic        clk_en_in,
    input wire logic [7:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic        pwm_output_a_out,
    input wire logic        pwm_output_b_out,
    input wire logic        fine_edge_out,
    input wire logic [7:0]  fine_steps_out
);
    logic [1:0] mode_reg;
    logic       pol_reg;
    logic [2:0] age_reg;
    logic       imm_reg;
    logic       run_reg;
    wire        cfg_wr = wr_in && clk_en_in && (addr_in == 8'hc0 || addr_in == 8'h07);
    wire        settled = age_reg >= 3'h4;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mode_reg <= 2'h0;
            pol_reg  <= 1'b0;
            age_reg  <= 3'h0;
            imm_reg  <= 1'b0;
            run_reg  <= 1'b0;
        end
        else
        begin
            if (cfg_wr && addr_in == 8'hc0)
                mode_reg <= wdata_in[1:0];
            if (cfg_wr && addr_in == 8'h07)
                pol_reg <= wdata_in[1];
            // compare-a extension reads back at once when its shadow is bypassed or the channel is stopped
            if (cfg_wr && addr_in == 8'hc0)
                imm_reg <= wdata_in[2] || wdata_in[4:3] == 2'h3;
            if (cfg_wr && addr_in == 8'h07)
                run_reg <= wdata_in[0];
            age_reg <= cfg_wr ? 3'h0 : (settled ? 3'h4 : age_reg + 3'h1);
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_rb(a, m);
        (wr_in && clk_en_in && addr_in == a) ##1 (rd_in && clk_en_in && addr_in == a)
            |=> (rdata_out & m) == ($past(wdata_in, 2) & m);
    endproperty

    AST_RD_IDLE: assert property (clk_en_in && !rd_in |=> rdata_out == 16'h0000)
        else $error("read data not cleared");
    AST_CFG_RB: assert property (p_rb(8'hc0, 16'h001f))
        else $error("config readback wrong");
    AST_COMPARE_A_VALUE_RB: assert property (p_rb(8'h10, (imm_reg || !run_reg) ? 16'hffff : 16'h00ff))
        else $error("compare-a extension readback wrong");
    AST_PHASE_RB: assert property (p_rb(8'h04, 16'hff00))
        else $error("phase extension readback wrong");
    AST_STEPS_IDLE: assert property (!fine_edge_out |-> fine_steps_out == 8'h00)
        else $error("step count without fine edge");
    AST_PULSE: assert property (fine_edge_out ##1 clk_en_in |-> !fine_edge_out)
        else $error("fine edge longer than one cycle");
    AST_ON_A: assert property (fine_edge_out |-> pwm_output_a_out != $past(pwm_output_a_out))
        else $error("fine edge without output a transition");
    AST_EDGE_RISE: assert property (fine_edge_out && settled && mode_reg == 2'h1 |-> pwm_output_a_out == !pol_reg)
        else $error("fine edge not on rising edge");
    AST_EDGE_FALL: assert property (fine_edge_out && settled && mode_reg == 2'h2 |-> pwm_output_a_out == pol_reg)
        else $error("fine edge not on falling edge");
    AST_EDGE_OFF: assert property (settled && mode_reg == 2'h0 |-> !fine_edge_out)
        else $error("fine edge while mode off");

    cover property (fine_edge_out && mode_reg == 2'h3);
    cover property (fine_edge_out && fine_steps_out == 8'hff);
    cover property (rd_in && addr_in == 8'hc0);
endmodule

bind fep_top fep_top_properties u_fep_top_properties
(
    .core_clk_in      (core_clk_in),
    .rst_n_in         (rst_n_in),
    .clk_en_in        (clk_en_in),
    .addr_in          (addr_in),
    .wdata_in         (wdata_in),
    .wr_in            (wr_in),
    .rd_in            (rd_in),
    .rdata_out        (rdata_out),
    .pwm_output_a_out (pwm_output_a_out),
    .pwm_output_b_out (pwm_output_b_out),
    .fine_edge_out    (fine_edge_out),
    .fine_steps_out   (fine_steps_out)
);

/* File: fep_gate_drv.sv */
// Purpose: gate driver stand-in on both pwm outputs
// Assumes: edges sampled on the system clock
// Notes:   counts let the bench compare fine marks with real transitions
`timescale 1ns/1ps
module fep_gate_drv
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        gate_a_in,
    input  wire logic        gate_b_in,
    input  wire logic        fine_in,
    input  wire logic [7:0]  steps_in,
    output logic      [15:0] a_rise_out,
    output logic      [15:0] a_fall_out,
    output logic      [15:0] b_rise_out,
    output logic      [15:0] fine_cnt_out,
    output logic      [7:0]  steps_out
);
    logic a_prev;
    logic b_prev;

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            {a_rise_out, a_fall_out, b_rise_out, fine_cnt_out} <= '0;
            steps_out <= 8'h00;
            a_prev    <= 1'b0;
            b_prev    <= 1'b0;
        end
        else
        begin
            a_prev     <= gate_a_in;
            b_prev     <= gate_b_in;
            a_rise_out <= a_rise_out + {15'h0, gate_a_in & !a_prev};
            a_fall_out <= a_fall_out + {15'h0, !gate_a_in & a_prev};
            b_rise_out <= b_rise_out + {15'h0, gate_b_in & !b_prev};
            if (fine_in)
            begin
                // the switch lands steps_in fractions of a clock after the coarse edge
                fine_cnt_out <= fine_cnt_out + 16'h0001;
                steps_out    <= steps_in;
            end
        end
    end
endmodule

/* File: fine_edge_pwm_extension_test.sv */
// Purpose: self-checking bench for fep_top
// Assumes: clock enable held high; registers addressed by index
// Notes:   fine marks are compared with edge counts seen by the gate driver
`timescale 1ns/1ps
module fine_edge_pwm_extension_test;
    logic        clk;
    logic        rst_n;
    logic        clk_en;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        pwm_a;
    logic        pwm_b;
    logic        fine;
    logic [7:0]  steps;
    logic [15:0] a_rise, a_fall, b_rise, fine_cnt;
    logic [7:0]  drv_steps;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;

    fep_top u_fep_top (.core_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .pwm_output_a_out(pwm_a),
        .pwm_output_b_out(pwm_b), .fine_edge_out(fine), .fine_steps_out(steps));
    fep_gate_drv u_fep_gate_drv (.core_clk_in(clk), .rst_n_in(rst_n), .gate_a_in(pwm_a), .gate_b_in(pwm_b),
        .fine_in(fine), .steps_in(steps), .a_rise_out(a_rise), .a_fall_out(a_fall), .b_rise_out(b_rise),
        .fine_cnt_out(fine_cnt), .steps_out(drv_steps));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
        wr    <= w;
        rd    <= r;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        op(1'b1, 1'b0, a, d);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        op(1'b0, 1'b1, a, 16'h0000);
        #1;
        chk(rdata, exp);
    endtask

    task automatic idle(input int n);
        op(1'b0, 1'b0, 8'h00, 16'h0000);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // three periods of 20 counts; the first cycles let an old mode drain
    task automatic win(input logic [1:0] m, input logic [7:0] st, input logic blank);
        logic [15:0] r0, f0, n0, b0;
        idle(6);
        {r0, f0, n0, b0} = {a_rise, a_fall, fine_cnt, b_rise};
        idle(60);
        r0 = a_rise - r0;
        f0 = a_fall - f0;
        n0 = fine_cnt - n0;
        chk(n0, blank ? 16'h0 : (m == 2'h1 ? r0 : m == 2'h2 ? f0 : m == 2'h3 ? r0 + f0 : 16'h0));
        chk({15'h0, f0 != 16'h0}, 16'h0001);
        chk({15'h0, b_rise != b0}, 16'h0001);
        if (m != 2'h0 && !blank)
            chk({8'h00, drv_steps}, {8'h00, st});
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n  = 1'b0;
        clk_en = 1'b1;
        wr     = 1'b0;
        rd     = 1'b0;
        addr   = 8'h00;
        wdata  = 16'h0000;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_reg(8'hc0, 16'h0000);
        rd_reg(8'h05, 16'hffff);
        wr_reg(8'h04, 16'h2a00);
        rd_reg(8'h04, 16'h2a00);
        wr_reg(8'h10, 16'h1780);
        rd_reg(8'h10, 16'h1780);
        wr_reg(8'hc0, 16'h001a);
        rd_reg(8'hc0, 16'h001a);
        wr_reg(8'h55, 16'hffff);
        rd_reg(8'hc0, 16'h001a);
        // coarse channel first, fine configuration after it
        wr_reg(8'h05, 16'h0013);
        rd_reg(8'h05, 16'h0013);
        wr_reg(8'h09, 16'h0008);
        wr_reg(8'h07, 16'h0019);
        wr_reg(8'h10, 16'h1680);
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(8'hc0, 16'h0018 | 16'(m) | (m == 3 ? 16'h0004 : 16'h0000));
            win(2'(m), m == 3 ? 8'h2a : 8'h16, 1'b0);
        end
        wr_reg(8'hc0, 16'h001a);
        wr_reg(8'h09, 16'h0002);
        win(2'h2, 8'h16, 1'b1);
        wr_reg(8'h09, 16'h0003);
        win(2'h2, 8'h16, 1'b0);
        wr_reg(8'hc0, 16'h0002);
        wr_reg(8'h07, 16'h0001);
        wr_reg(8'h10, 16'hff00);
        rd_reg(8'h10, 16'h1600);
        win(2'h2, 8'hff, 1'b0);
        rd_reg(8'h10, 16'hff00);
        wr_reg(8'hc0, 16'h0007);
        wr_reg(8'h10, 16'h4400);
        rd_reg(8'h10, 16'h4400);
        wr_reg(8'h04, 16'h5500);
        wr_reg(8'hc1, 16'h0001);
        rd_reg(8'hc1, 16'h0001);
        win(2'h3, 8'h55, 1'b0);
        op(1'b0, 1'b1, 8'hc2, 16'h0000);
        #1;
        chk({15'h0, rdata[7:0] != 8'h00}, 16'h0001);
        wr_reg(8'hc1, 16'h0000);
        idle(1);
        rd_reg(8'hc2, 16'h0000);
        end_sim();
    end
endmodule
